// ===== rtl/fru_uart.sv
// fixed rate full duplex serial port with APB register access
// assumes ref_clk_in is the free running reference and rxd_in an
// asynchronous pin; both are synchronised here
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module fru_uart import fru_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins and reference
    input wire logic ref_clk_in,
    input wire logic rxd_in,
    output logic txd_out
);

    // ************************************************
    // decode helpers
    // ************************************************
    // only 01 and 10 are frame modes; other codes stay silent
    function automatic logic mode_ok(input fru_ctrl_t c);
        mode_ok = c.frame_mode_select_hi ^ c.frame_mode_select_lo;
    endfunction

    function automatic logic mode_nine(input fru_ctrl_t c);
        mode_nine = c.frame_mode_select_hi & ~c.frame_mode_select_lo;
    endfunction

    function automatic fru_sel_t decode(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_CTRL: decode = FRU_SEL_CTRL;
            ADDR_DATA: decode = FRU_SEL_DATA;
            ADDR_PWR: decode = FRU_SEL_PWR;
            default: decode = FRU_SEL_NONE;
        endcase
    endfunction

    fru_ctrl_t ctrl;
    logic baud_double_bit;
    logic [7:0] rx_buf;
    logic ref_s1, ref_s2, ref_s3;
    logic rxd_s1, rxd_s2, rxd_s3;
    fru_state_t tx_state, rx_state;
    logic [4:0] tx_cnt, rx_cnt;
    logic [2:0] tx_bit, rx_bit;
    logic [7:0] tx_shift, rx_shift;
    logic tx_nine, tx_is_nine, rx_is_nine, rx_nine;

    // ************************************************
    // synchronisers and reference tick
    // ************************************************
    // first stage feeds only the second; third is for edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            rxd_s3 <= 1'b1;
        end else begin
            ref_s1 <= ref_clk_in;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            rxd_s1 <= rxd_in;
            rxd_s2 <= rxd_s1;
            rxd_s3 <= rxd_s2;
        end
    end

    // one enable per reference period, not a divided pclk
    wire ref_tick = ref_s2 & ~ref_s3;
    // 16 or 8 reference ticks per bit
    wire [4:0] tpb = baud_double_bit ? TK_FAST : TK_SLOW;
    wire [4:0] tpb_m1 = tpb - 5'h01;
    wire [4:0] half_m1 = (tpb >> 1) - 5'h01;

    // ************************************************
    // apb slave
    // ************************************************
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready;
    wire fru_sel_t sel = decode(paddr);
    wire wr_ctrl = acc & pwrite & (sel == FRU_SEL_CTRL);
    wire wr_data = acc & pwrite & (sel == FRU_SEL_DATA);
    wire wr_pwr = acc & pwrite & (sel == FRU_SEL_PWR);
    // write data seen through the control field layout
    wire fru_ctrl_t wf = fru_ctrl_t'(pwdata[7:0]);

    // answer in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & (sel == FRU_SEL_NONE);
            if (setup & ~pwrite) begin
                case (sel)
                    FRU_SEL_CTRL: prdata <= {24'h0, ctrl};
                    // separate receive register
                    FRU_SEL_DATA: prdata <= {24'h0, rx_buf};
                    FRU_SEL_PWR: prdata <= 32'(baud_double_bit) << PWR_DOUBLE_POS;
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // baud doubling starts low, slow rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_double_bit <= 1'b0;
        end else if (wr_pwr) begin
            baud_double_bit <= pwdata[PWR_DOUBLE_POS];
        end
    end

    // ************************************************
    // transmitter
    // ************************************************
    wire tx_bit_end = ref_tick & (tx_cnt == tpb_m1);
    wire tx_last = tx_bit == LAST_DATA_BIT;
    wire tx_enter_stop = tx_bit_end & ((tx_state == FRU_NINTH) |
        ((tx_state == FRU_DATA) & tx_last & ~tx_is_nine));
    wire tx_load = wr_data & mode_ok(ctrl);

    // runs on its own, independent of the receiver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= FRU_IDLE;
            tx_cnt <= 5'h0;
            tx_bit <= 3'h0;
            tx_shift <= 8'h0;
            tx_nine <= 1'b0;
            tx_is_nine <= 1'b0;
            txd_out <= 1'b1;
        end else if (tx_load) begin
            // write to buffer loads and starts a frame
            // a write mid frame restarts it; software should wait
            tx_state <= FRU_START;
            tx_cnt <= 5'h0;
            tx_bit <= 3'h0;
            tx_shift <= pwdata[7:0];
            tx_nine <= ctrl.tx_ninth_bit;
            tx_is_nine <= mode_nine(ctrl);
            txd_out <= 1'b0;
        end else if (ref_tick & (tx_state != FRU_IDLE)) begin
            tx_cnt <= tx_bit_end ? 5'h0 : tx_cnt + 5'h01;
            if (tx_bit_end) begin
                case (tx_state)
                    FRU_START: begin
                        tx_state <= FRU_DATA;
                        txd_out <= tx_shift[0];
                    end
                    FRU_DATA: begin
                        // least significant bit first
                        tx_shift <= tx_shift >> 1;
                        tx_bit <= tx_bit + 3'h1;
                        if (!tx_last) begin
                            txd_out <= tx_shift[1];
                        end else if (tx_is_nine) begin
                            tx_state <= FRU_NINTH;
                            txd_out <= tx_nine;
                        end else begin
                            tx_state <= FRU_STOP;
                            txd_out <= 1'b1;
                        end
                    end
                    FRU_NINTH: begin
                        tx_state <= FRU_STOP;
                        txd_out <= 1'b1;
                    end
                    FRU_STOP: tx_state <= FRU_IDLE;
                    default: tx_state <= FRU_IDLE;
                endcase
            end
        end
    end

    // ************************************************
    // receiver
    // ************************************************
    wire rx_bit_end = ref_tick & (rx_cnt == tpb_m1);
    wire rx_stop_mid = (rx_state == FRU_STOP) & rx_bit_end;
    // drop when the earlier byte is still flagged unread
    wire rx_commit = rx_stop_mid & ~ctrl.rx_done_flag;
    wire rx_fall = rxd_s3 & ~rxd_s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= FRU_IDLE;
            rx_cnt <= 5'h0;
            rx_bit <= 3'h0;
            rx_shift <= 8'h0;
            rx_nine <= 1'b0;
            rx_is_nine <= 1'b0;
        end else if (!ctrl.rx_enable | !mode_ok(ctrl)) begin
            // disabled receiver drops any frame in flight
            rx_state <= FRU_IDLE;
        end else begin
            case (rx_state)
                FRU_IDLE: begin
                    // start on a falling edge
                    if (rx_fall) begin
                        rx_state <= FRU_START;
                        rx_cnt <= 5'h0;
                        rx_bit <= 3'h0;
                        rx_is_nine <= mode_nine(ctrl);
                    end
                end
                FRU_START: begin
                    if (ref_tick) begin
                        rx_cnt <= rx_cnt + 5'h01;
                        // mid start bit check rejects glitches
                        if (rx_cnt == half_m1) begin
                            rx_cnt <= 5'h0;
                            rx_state <= rxd_s2 ? FRU_IDLE : FRU_DATA;
                        end
                    end
                end
                FRU_DATA, FRU_NINTH, FRU_STOP: begin
                    if (ref_tick) begin
                        rx_cnt <= rx_bit_end ? 5'h0 : rx_cnt + 5'h01;
                    end
                    if (rx_bit_end) begin
                        case (rx_state)
                            FRU_DATA: begin
                                rx_shift <= {rxd_s2, rx_shift[7:1]};
                                rx_bit <= rx_bit + 3'h1;
                                if (rx_bit == LAST_DATA_BIT) begin
                                    rx_state <= rx_is_nine ? FRU_NINTH :
                                        FRU_STOP;
                                end
                            end
                            FRU_NINTH: begin
                                rx_nine <= rxd_s2;
                                rx_state <= FRU_STOP;
                            end
                            // back to idle at mid stop, ready for next
                            default: rx_state <= FRU_IDLE;
                        endcase
                    end
                end
                default: rx_state <= FRU_IDLE;
            endcase
        end
    end

    // holding register, loaded only when the old byte was taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf <= 8'h0;
        end else if (rx_commit) begin
            rx_buf <= rx_shift;
        end
    end

    // ************************************************
    // control/status register
    // ************************************************
    // hardware sets win over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= fru_ctrl_t'(CTRL_RST);
        end else begin
            if (wr_ctrl) begin
                ctrl.frame_mode_select_hi <= wf.frame_mode_select_hi;
                ctrl.frame_mode_select_lo <= wf.frame_mode_select_lo;
                ctrl.rx_enable <= wf.rx_enable;
                ctrl.tx_ninth_bit <= wf.tx_ninth_bit;
                ctrl.tx_done_flag <= wf.tx_done_flag;
                ctrl.rx_done_flag <= wf.rx_done_flag;
            end
            // bit 5 never stored, reads zero
            ctrl.multiproc_filter_bit <= 1'b0;
            if (tx_enter_stop) begin
                ctrl.tx_done_flag <= 1'b1;
            end
            if (rx_commit) begin
                ctrl.rx_done_flag <= 1'b1;
                // ninth bit in 9-bit, stop bit in 8-bit
                ctrl.rx_ninth_bit <= rx_is_nine ? rx_nine : rxd_s2;
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_load;
        wr_data ##0 mode_ok(ctrl);
    endsequence

    sequence s_start_out;
        (tx_state == FRU_START) && !txd_out;
    endsequence

    AST_TX_LOAD: assert property (s_load |=> s_start_out)
        else $error("buffer write did not start a frame");

    AST_NO_MODE: assert property (wr_data && !mode_ok(ctrl) &&
        tx_state == FRU_IDLE |=> tx_state == FRU_IDLE)
        else $error("frame started in an unsupported mode");

    AST_TX_FLAG: assert property (tx_enter_stop |=>
        ctrl.tx_done_flag && txd_out && tx_state == FRU_STOP)
        else $error("tx flag not set at stop bit start");

    AST_RX_TAKE: assert property (rx_commit |=>
        ctrl.rx_done_flag && rx_buf == $past(rx_shift))
        else $error("received byte not stored with flag");

    AST_RX_DROP: assert property (rx_stop_mid && ctrl.rx_done_flag |=>
        $stable(rx_buf))
        else $error("unread byte overwritten");

    AST_RX_OFF: assert property (!ctrl.rx_enable |=>
        rx_state == FRU_IDLE)
        else $error("receiver active while disabled");

    AST_NINTH_OUT: assert property (tx_state == FRU_NINTH |->
        txd_out == tx_nine)
        else $error("ninth bit not driven");

    AST_RB8: assert property (rx_commit |=> ctrl.rx_ninth_bit ==
        $past(rx_is_nine ? rx_nine : rxd_s2))
        else $error("received ninth bit wrong");

    AST_BIT_LEN: assert property (tx_bit_end |=> tx_cnt == 5'h0 &&
        $past(tx_cnt) == (baud_double_bit ? TK_FAST : TK_SLOW) - 5'h01)
        else $error("bit length differs from baud setting");

    AST_BIT5: assert property (setup && !pwrite && sel == FRU_SEL_CTRL
        |=> prdata[5] == 1'b0)
        else $error("unused control bit read non zero");

    // a registered ready only ever lasts one cycle
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");

    AST_UNMAPPED: assert property (setup && sel == FRU_SEL_NONE |=>
        pready && pslverr)
        else $error("unmapped access not refused");

    // line rests at the stop level between frames
    AST_TXD_IDLE: assert property (tx_state == FRU_IDLE |->
        txd_out)
        else $error("transmit line low while idle");

    // an enabled receiver leaves idle on the first falling edge
    AST_RX_BEGIN: assert property (rx_fall &&
        rx_state == FRU_IDLE && ctrl.rx_enable && mode_ok(ctrl) |=>
        rx_state == FRU_START)
        else $error("receiver missed a start edge");

    // flags stay up until software writes the control register
    AST_TXF_HOLD: assert property (ctrl.tx_done_flag &&
        !wr_ctrl |=> ctrl.tx_done_flag)
        else $error("tx flag cleared by hardware");

    AST_RXF_HOLD: assert property (ctrl.rx_done_flag &&
        !wr_ctrl |=> ctrl.rx_done_flag)
        else $error("rx flag cleared by hardware");

endmodule

// ===== rtl/fru_pkg.sv
// constants and types of the fixed rate serial port
// assumes a single pclk domain and an APB slave wrapper in fru_uart
//
// Overview of operation
// - mode bits 0,1 select 8-bit frames
// - mode bits 1,0 select 9-bit frames
// - no shift, variable rate or timer modes
// - multiprocessor filter bit 5 does nothing
// - bit timing from 76.8 kHz reference
// - transmitter and receiver run concurrently
// - second byte dropped if first unread
// - buffer write loads tx, read gives rx
// - 8-bit frame: start, 8 data, stop
// - 8-bit mode stores stop bit as ninth
// - 9-bit frame: start, 8 data, ninth, stop
// - 9-bit mode sends software ninth bit
// - 9-bit mode stores ninth, ignores stop
// - baud is reference/16, doubled gives /8
// - baud doubling bit resets to zero
// - buffer write starts frame transmission
// - reception starts only while enabled
// - tx flag set at stop bit start
// - rx flag set mid stop bit
package fru_pkg;

    // ************************************************
    // timing
    // ************************************************
    localparam int REF_HZ = 76800;
    localparam int BAUD_SLOW = 4800;
    localparam int BAUD_FAST = 9600;
    localparam logic [4:0] TK_SLOW = 5'(REF_HZ / BAUD_SLOW);
    localparam logic [4:0] TK_FAST = 5'(REF_HZ / BAUD_FAST);
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    // ************************************************
    // register map (index, byte address is four times it)
    // ************************************************
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_CTRL = 8'h98;
    localparam logic [7:0] IDX_DATA = 8'h99;
    localparam logic [7:0] IDX_PWR = 8'h9a;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'({IDX_CTRL, 2'h0});
    localparam logic [ADDR_W-1:0] ADDR_DATA = ADDR_W'({IDX_DATA, 2'h0});
    localparam logic [ADDR_W-1:0] ADDR_PWR = ADDR_W'({IDX_PWR, 2'h0});
    localparam int PWR_DOUBLE_POS = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // control/status layout, bit 7 first
    typedef struct packed {
        logic frame_mode_select_hi;
        logic frame_mode_select_lo;
        logic multiproc_filter_bit;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } fru_ctrl_t;

    typedef enum logic [1:0] {
        FRU_SEL_NONE = 2'b00,
        FRU_SEL_CTRL = 2'b01,
        FRU_SEL_DATA = 2'b10,
        FRU_SEL_PWR = 2'b11
    } fru_sel_t;

    typedef enum logic [2:0] {
        FRU_IDLE = 3'b000,
        FRU_START = 3'b001,
        FRU_DATA = 3'b010,
        FRU_NINTH = 3'b011,
        FRU_STOP = 3'b100
    } fru_state_t;

endpackage

// ===== verification/fru_remote.sv
// remote serial end: drives frames into rxd and captures txd frames
// assumes the caller hands in the bit length in pclk cycles
`timescale 1ns/1ps
module fru_remote (
    // clock
    input wire logic pclk,
    // serial lines
    input wire logic txd_in,
    output logic rxd_out
);
    // ********
    // sender
    // ********
    // idle line rests high, like a pulled-up pin
    initial rxd_out = 1'b1;

    // bit 0 goes first: start, data lsb first, [ninth], stop
    task automatic send(input logic [10:0] bits, input int n,
            input int bc);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk) rxd_out <= bits[i];
            repeat (bc - 1) @(posedge pclk);
        end
        @(posedge pclk) rxd_out <= 1'b1;
    endtask

    // ********
    // receiver
    // ********
    // mid-bit capture; all ones back when no start bit shows
    task automatic recv(input int n, input int bc,
            output logic [10:0] bits);
        int w;
        bits = 11'h7ff;
        w = 0;
        while (txd_in !== 1'b0 && w < 24 * bc) begin
            @(posedge pclk);
            w++;
        end
        if (txd_in === 1'b0) begin
            repeat (bc / 2) @(posedge pclk);
            for (int i = 0; i < n; i++) begin
                bits[i] = txd_in;
                repeat (bc) @(posedge pclk);
            end
        end
    endtask
endmodule

// ===== verification/tb_fixed_rate_uart.sv
// bench for the fixed rate serial port over apb and its serial pins
// assumes fru_uart and the fru_remote model of the far end
`timescale 1ns/1ps
module tb_fixed_rate_uart import fru_pkg::*; ;
    // ********
    // clocks and wiring
    // ********
    // ref runs faster than real so runs stay short; bits count ref ticks
    localparam int RC = 16;
    localparam int BS = RC * int'(TK_SLOW);
    localparam int BF = RC * int'(TK_FAST);
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, ref_clk_in = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, rxd_in, txd_out, e;
    logic [10:0] b;
    int n_errors = 0, samples_checked = 0;

    always #25 pclk = ~pclk;
    always #(RC * 25) ref_clk_in = ~ref_clk_in;

    fru_uart uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_clk_in(ref_clk_in), .rxd_in(rxd_in),
        .txd_out(txd_out));
    fru_remote rem (.pclk(pclk), .txd_in(txd_out), .rxd_out(rxd_in));

    // ********
    // shared tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [31:0] d, output logic [31:0] rd,
            output logic err);
        int w;
        w = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, 32'(d), x, y);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
        logic y;
        apb(1'b0, a, 32'h0, v, y);
    endtask

    // ********
    // scenarios
    // ********
    // reset values, unmapped slot, dead bit 5, refused modes
    task automatic t_regs();
        rd(ADDR_PWR, r);
        chk(r, 32'h0);
        rd(ADDR_DATA, r);
        chk(r, 32'h0);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk(32'(e), 32'h1);
        wr(ADDR_CTRL, 8'h20);
        rd(ADDR_CTRL, r);
        chk(r, 32'h0);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, i ? 8'hc0 : 8'h00);
            fork
                rem.recv(10, BS, b);
                wr(ADDR_DATA, 8'h0f);
            join
            chk(32'(b), 32'h7ff);
        end
        $display("test regs done");
    endtask

    // 8-bit frame at the slow rate, done flag at stop start
    task automatic t_tx8();
        wr(ADDR_CTRL, 8'h40);
        fork
            rem.recv(10, BS, b);
            begin
                wr(ADDR_DATA, 8'ha5);
                repeat (8 * BS) @(posedge pclk);
                rd(ADDR_CTRL, r);
                chk(r, 32'h40);
                repeat (3 * BS / 2) @(posedge pclk);
                rd(ADDR_CTRL, r);
                chk(r, 32'h42);
            end
        join
        chk(32'(b), 32'({2'b11, 8'ha5, 1'b0}));
        wr(ADDR_CTRL, 8'h40);
        rd(ADDR_CTRL, r);
        chk(r, 32'h40);
        $display("test tx8 done");
    endtask

    // 9-bit frames at the fast rate, both ninth bit values
    task automatic t_tx9();
        wr(ADDR_PWR, 8'h80);
        rd(ADDR_PWR, r);
        chk(r, 32'h80);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CTRL, k ? 8'h88 : 8'h80);
            fork
                rem.recv(11, BF, b);
                wr(ADDR_DATA, 8'h3c);
            join
            chk(32'(b), 32'({1'b1, k[0], 8'h3c, 1'b0}));
        end
        $display("test tx9 done");
    endtask

    // receive while sending; flag only from mid stop on
    task automatic t_rx();
        wr(ADDR_CTRL, 8'h50);
        fork
            rem.send(11'({1'b1, 8'h5a, 1'b0}), 10, BF);
            rem.recv(10, BF, b);
            begin
                wr(ADDR_DATA, 8'hc3);
                repeat (9 * BF) @(posedge pclk);
                rd(ADDR_CTRL, r);
                chk(r & 32'h1, 32'h0);
            end
        join
        rd(ADDR_CTRL, r);
        chk(r, 32'h57);
        rd(ADDR_DATA, r);
        chk(r, 32'h5a);
        chk(32'(b), 32'({2'b11, 8'hc3, 1'b0}));
        $display("test rx done");
    endtask

    // second byte lost while first unclaimed, then received once freed
    task automatic t_ovr();
        rem.send(11'({1'b1, 8'h99, 1'b0}), 10, BF);
        rd(ADDR_DATA, r);
        chk(r, 32'h5a);
        wr(ADDR_CTRL, 8'h50);
        rem.send(11'({1'b1, 8'h66, 1'b0}), 10, BF);
        rd(ADDR_DATA, r);
        chk(r, 32'h66);
        $display("test overrun done");
    endtask

    // receiver off, then 9-bit receive ignoring the stop bit
    task automatic t_rx9();
        wr(ADDR_CTRL, 8'h40);
        rem.send(11'({1'b1, 8'h12, 1'b0}), 10, BF);
        rd(ADDR_CTRL, r);
        chk(r, 32'h44);
        rd(ADDR_DATA, r);
        chk(r, 32'h66);
        wr(ADDR_CTRL, 8'h90);
        rem.send(11'({1'b1, 1'b0, 8'ha7, 1'b0}), 11, BF);
        rd(ADDR_CTRL, r);
        chk(r, 32'h91);
        rd(ADDR_DATA, r);
        chk(r, 32'ha7);
        $display("test rx9 done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ********
    // sequence and watchdog
    // ********
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx8();
        t_tx9();
        t_rx();
        t_ovr();
        t_rx9();
        final_report();
    end

    // about two and a half times the expected run length
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        final_report();
    end
endmodule
